// ### core/adc_seq_pkg.sv
// Purpose: Shared constants and carrier types for the converter sequencer control.
// Assumes: One 125 MHz clock; analog levels arrive already digitised in millivolts.
// Notes: Timing counts come from the conversion and settle times at the clock rate.
package adc_seq_pkg;

  localparam int DATA_W = 12;
  localparam int CHAN_W = 4;
  localparam int SLOTS = 16;
  localparam int HALF_SLOTS = 8;
  localparam int MV_W = 12;

  localparam logic [DATA_W-1:0] CODE_ZERO = 12'h000;
  localparam logic [DATA_W-1:0] CODE_FULL = 12'hFFF;
  localparam logic [12:0] CODE_SCALE = 13'h1000;
  localparam logic [MV_W-1:0] FULL_RANGE_MV = 12'hBB8;

  localparam int CLK_MHZ = 125;
  localparam int CONV_TIME_NS = 80;
  // Longest conversion time, so the count rounds down
  localparam int CONV_CYCLES_INT = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] CONV_CYCLES = 4'(CONV_CYCLES_INT);
  localparam int SETTLE_TIME_US = 1000;
  localparam int SETTLE_CYCLES_INT = SETTLE_TIME_US * CLK_MHZ;

  localparam logic [3:0] PTR_FIRST = 4'h0;
  localparam logic [3:0] PTR_STEP = 4'h1;

  typedef enum logic [1:0] {
    ENG_IDLE = 2'h0,
    ENG_ACQ = 2'h1,
    ENG_CONV = 2'h3,
    ENG_DONE = 2'h2
  } eng_state_type;

  typedef struct packed {
    logic sw_start_a;
    logic sw_start_b;
    logic pwm_conversion_trigger_a;
    logic pwm_conversion_trigger_b;
    logic external_interrupt_two;
  } trigger_type;

  typedef struct packed {
    logic cascade;
    logic start_stop;
    logic ext_trigger_enable;
    logic every_other_a;
    logic every_other_b;
    logic [3:0] acq_prescale;
    logic [2:0] max_conv_a;
    logic [2:0] max_conv_b;
    logic [3:0] max_conv_casc;
    logic [1:0] ref_select;
  } seq_cfg_type;

endpackage : adc_seq_pkg

// ### core/adc_sequencer_control.sv
// Purpose: Two 8-slot or one 16-slot autosequencer around a single converter.
// Assumes: All inputs synchronous to clk; software bits arrive as plain ports.
// Notes: Sequencer A has priority for the shared converter.
//
// Summary of operation
// - Code is clamped, scaled, truncated input level
// - Cascaded: up to sixteen slots, any channel each
// - Dual 8-slot or cascaded 16-slot sequencing
// - Dual mode: each sequencer uses own eight inputs
// - Each slot writes its own result register
// - Same channel may repeat across slots
// - One converter serves both sequencers in turn
// - Software, PWM or external line start sequences
// - PWM triggers A and B independent in dual
// - Interrupt every or every second sequence end
// - Start/stop mode: each trigger converts one slot
// - Acquisition window has its own prescale
// - Conversion phase 80 ns; one slot per 13 cycles at least
// - Registers on system clock, timing on fast clock
// - Module clock enable low after reset
// - Reset reaches defaults, analog stays powered down
// - Registers frozen until module clock enable set
// - Enable powers analog; software waits settle time
// - Halt powers analog down, registers intact
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control
  import adc_seq_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYCLES_INT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic converter_clock_enable,
  input wire logic halt,
  input wire logic fast_peripheral_clock_en,
  input wire seq_cfg_type cfg,
  input wire logic [SLOTS-1:0][CHAN_W-1:0] chan_sel,
  input wire trigger_type trig,
  input wire logic [MV_W-1:0] analog_input_pin_mv,
  input wire logic [MV_W-1:0] analog_low_reference_mv,
  output logic [CHAN_W-1:0] mux_channel_r,
  output logic sample_hold_r,
  output logic analog_power_up_r,
  output logic converter_ready_r,
  output logic [1:0] reference_select_r,
  output logic [SLOTS-1:0][DATA_W-1:0] results_r,
  output logic [1:0] sequence_done_r,
  output logic [1:0] seq_irq_r,
  output logic [1:0] seq_busy_r
);

  ////////////////////////////////////////////////////////////////////////////////
  // Clocking and power

  logic enable_r;
  logic reg_run;
  logic eng_run;
  logic [31:0] settle_cnt_r;

  // Register logic only advances with the module clock enabled
  assign reg_run = clk_en && enable_r;
  // Conversion timing also needs the fast clock, which halt stops
  assign eng_run = reg_run && !halt && fast_peripheral_clock_en;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      enable_r <= 1'b0;
    end else if (clk_en) begin
      enable_r <= converter_clock_enable;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      analog_power_up_r <= 1'b0;
      settle_cnt_r <= '0;
      converter_ready_r <= 1'b0;
    end else if (clk_en) begin
      analog_power_up_r <= enable_r && !halt;
      if (!(enable_r && !halt)) begin
        settle_cnt_r <= '0;
        converter_ready_r <= 1'b0;
      end else if (settle_cnt_r == 32'(SETTLE_CYCLES)) begin
        converter_ready_r <= 1'b1;
      end else begin
        settle_cnt_r <= settle_cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      reference_select_r <= 2'h0;
    end else if (reg_run) begin
      reference_select_r <= cfg.ref_select;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencers

  eng_state_type st_r;
  logic owner_r;
  logic [3:0] slot_r;
  logic [3:0] ptr_r [2];
  logic [1:0] act_r;
  logic [1:0] pend_r;
  logic [1:0] odd_r;
  logic [1:0] hit;
  logic [1:0] last;
  logic [1:0] done_this;

  // The sequencer B PWM trigger goes to the single sequencer when cascaded; software start B is dropped
  always_comb begin
    hit[0] = trig.sw_start_a || trig.pwm_conversion_trigger_a
      || (cfg.cascade && trig.pwm_conversion_trigger_b)
      || (cfg.ext_trigger_enable && trig.external_interrupt_two);
    hit[1] = !cfg.cascade && (trig.sw_start_b || trig.pwm_conversion_trigger_b);
    last[0] = cfg.cascade ? (ptr_r[0] == cfg.max_conv_casc)
                          : (ptr_r[0][2:0] == cfg.max_conv_a);
    last[1] = ptr_r[1][2:0] == cfg.max_conv_b;
  end

  genvar s;
  generate
    for (s = 0; s < 2; s++) begin : g_seq
      assign done_this[s] = eng_run && (st_r == ENG_DONE) && (owner_r == 1'(s));

      always_ff @(posedge clk) begin
        if (!rstn) begin
          ptr_r[s] <= PTR_FIRST;
          act_r[s] <= 1'b0;
          pend_r[s] <= 1'b0;
        end else if (reg_run) begin
          if (done_this[s]) begin
            if (last[s]) begin
              ptr_r[s] <= PTR_FIRST;
              act_r[s] <= pend_r[s] || hit[s];
            end else begin
              ptr_r[s] <= ptr_r[s] + PTR_STEP;
              // Start/stop waits for the next trigger between slots
              act_r[s] <= !cfg.start_stop || pend_r[s] || hit[s];
            end
            pend_r[s] <= 1'b0;
          end else if (hit[s]) begin
            // A trigger during a run is pended; continuous mode drops it unless it comes in the last slot
            if (act_r[s]) begin
              pend_r[s] <= 1'b1;
            end else begin
              act_r[s] <= 1'b1;
            end
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          sequence_done_r[s] <= 1'b0;
          seq_irq_r[s] <= 1'b0;
          odd_r[s] <= 1'b0;
        end else if (reg_run) begin
          sequence_done_r[s] <= done_this[s] && last[s];
          seq_irq_r[s] <= done_this[s] && last[s]
            && (!(s == 0 ? cfg.every_other_a : cfg.every_other_b) || odd_r[s]);
          if (done_this[s] && last[s]) begin
            odd_r[s] <= !odd_r[s];
          end
        end
      end

      always_ff @(posedge clk) begin
        if (!rstn) begin
          seq_busy_r[s] <= 1'b0;
        end else if (reg_run) begin
          seq_busy_r[s] <= act_r[s] || (ptr_r[s] != PTR_FIRST);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Shared conversion engine

  logic grant_b;
  logic [3:0] grant_slot;
  logic [CHAN_W-1:0] grant_chan;
  logic [3:0] cnt_r;
  logic [DATA_W-1:0] code;
  logic [DATA_W-1:0] held_code_r;

  sample_encoder u_encoder (
    .input_mv(analog_input_pin_mv),
    .low_ref_mv(analog_low_reference_mv),
    .code(code)
  );

  // Fixed priority: A first, so one converter is never shared at once
  always_comb begin
    grant_b = !act_r[0];
    if (cfg.cascade) begin
      grant_slot = ptr_r[0];
      grant_chan = chan_sel[ptr_r[0]];
    end else begin
      grant_slot = {grant_b, ptr_r[grant_b][2:0]};
      grant_chan = {grant_b, chan_sel[grant_slot][2:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_r <= ENG_IDLE;
      owner_r <= 1'b0;
      slot_r <= PTR_FIRST;
      cnt_r <= 4'h0;
      mux_channel_r <= '0;
      sample_hold_r <= 1'b0;
      held_code_r <= CODE_ZERO;
    end else if (eng_run) begin
      unique case (st_r)
        ENG_IDLE: begin
          if (act_r[0] || (act_r[1] && !cfg.cascade)) begin
            owner_r <= grant_b;
            slot_r <= grant_slot;
            mux_channel_r <= grant_chan;
            sample_hold_r <= 1'b1;
            cnt_r <= cfg.acq_prescale;
            st_r <= ENG_ACQ;
          end
        end
        ENG_ACQ: begin
          // Window is prescale plus one fast-clock cycles
          if (cnt_r == 4'h0) begin
            sample_hold_r <= 1'b0;
            held_code_r <= code;
            cnt_r <= CONV_CYCLES - 4'h1;
            st_r <= ENG_CONV;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ENG_CONV: begin
          if (cnt_r == 4'h0) begin
            st_r <= ENG_DONE;
          end else begin
            cnt_r <= cnt_r - 4'h1;
          end
        end
        ENG_DONE: begin
          st_r <= ENG_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      results_r <= '0;
    end else if (eng_run && st_r == ENG_DONE) begin
      results_r[slot_r] <= held_code_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [3:0] conv_seen_r;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_seen_r <= 4'h0;
    end else if (st_r != ENG_CONV) begin
      conv_seen_r <= 4'h0;
    end else if (eng_run) begin
      conv_seen_r <= conv_seen_r + 4'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_enable_after_reset;
    $rose(rstn) |-> !enable_r && !analog_power_up_r && !seq_busy_r[0];
  endproperty
  a_enable_after_reset: assert property (p_enable_after_reset)
    else $error("clock enable or analog power not low after reset");

  property p_frozen_when_off;
    (!enable_r && $past(rstn)) |=> $stable(results_r) && $stable(ptr_r[0]);
  endproperty
  a_frozen_when_off: assert property (p_frozen_when_off)
    else $error("register state moved with module clock off");

  property p_halt_powers_down;
    (clk_en && halt) |=> !analog_power_up_r ##1 !converter_ready_r;
  endproperty
  a_halt_powers_down: assert property (p_halt_powers_down)
    else $error("analog section powered during halt");

  property p_conv_length;
    (st_r == ENG_CONV && eng_run && cnt_r == 4'h0) |-> conv_seen_r == CONV_CYCLES - 4'h1;
  endproperty
  a_conv_length: assert property (p_conv_length)
    else $error("conversion phase length wrong");

  property p_result_write;
    (st_r == ENG_DONE && eng_run) |=> results_r[$past(slot_r)] == $past(held_code_r);
  endproperty
  a_result_write: assert property (p_result_write)
    else $error("result not written to slot register");

  property p_rewind;
    (sequence_done_r[0] && $past(reg_run)) |-> ptr_r[0] == PTR_FIRST && $past(st_r) == ENG_DONE;
  endproperty
  a_rewind: assert property (p_rewind)
    else $error("pointer not rewound at sequence end");

  property p_dual_group;
    (!cfg.cascade && $rose(sample_hold_r)) |-> mux_channel_r[CHAN_W-1] == owner_r;
  endproperty
  a_dual_group: assert property (p_dual_group)
    else $error("channel outside sequencer group");

  property p_irq_every;
    (sequence_done_r[0] && !$past(cfg.every_other_a)) |-> seq_irq_r[0];
  endproperty
  a_irq_every: assert property (p_irq_every)
    else $error("missing interrupt at sequence end");

  property p_irq_only_at_end;
    seq_irq_r != 2'h0 |-> (seq_irq_r & ~sequence_done_r) == 2'h0;
  endproperty
  a_irq_only_at_end: assert property (p_irq_only_at_end)
    else $error("interrupt without sequence end");

  c_cascade_end: cover property (cfg.cascade && sequence_done_r[0]);
  c_dual_both: cover property (sequence_done_r[0] ##[1:200] sequence_done_r[1]);
  c_start_stop: cover property (cfg.start_stop && act_r[0] ##1 !act_r[0] && ptr_r[0] != 4'h0);
  c_every_other: cover property (cfg.every_other_a && seq_irq_r[0]);

endmodule : adc_sequencer_control
`default_nettype wire

// ### core/sample_encoder.sv
// Purpose: Turns a sampled input level into a 12-bit code.
// Assumes: Levels in millivolts, scaled per 3 V above the low reference, full code at 3 V absolute.
// Notes: Pure combinational; the caller registers the result.
`timescale 1ns/100ps
`default_nettype none
module sample_encoder
  import adc_seq_pkg::*;
(
  input wire logic [MV_W-1:0] input_mv,
  input wire logic [MV_W-1:0] low_ref_mv,
  output logic [DATA_W-1:0] code
);

  logic [MV_W-1:0] diff;
  logic [24:0] scaled;

  always_comb begin
    diff = input_mv - low_ref_mv;
    scaled = (25'(diff) * 25'(CODE_SCALE)) / 25'(FULL_RANGE_MV);
    if (input_mv <= low_ref_mv) begin
      code = CODE_ZERO;
    end else if (input_mv >= FULL_RANGE_MV) begin
      code = CODE_FULL;
    end else begin
      // Fraction dropped by the integer divide
      code = scaled[DATA_W-1:0];
    end
  end

endmodule : sample_encoder
`default_nettype wire

// ### testbench/adc_sequencer_control_bench.sv
// Purpose: Self-checking bench for the converter sequencer control.
// Assumes: Short settle count; levels stay steady while a sequence runs.
// Notes: Channels, levels and lengths are random from a fixed seed.
`timescale 1ns/100ps
`default_nettype none
module adc_sequencer_control_bench
  import adc_seq_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic cce = 1'b0;
  logic halt = 1'b0;
  logic tick = 1'b1;
  logic slow = 1'b0;
  seq_cfg_type cfg = '0;
  logic [SLOTS-1:0][CHAN_W-1:0] chan_sel = '0;
  trigger_type trig = '0;
  logic [SLOTS-1:0][MV_W-1:0] lvl = '0;
  logic [MV_W-1:0] low_mv = '0;
  logic [MV_W-1:0] pin_mv;
  logic [CHAN_W-1:0] mux_ch;
  logic hold, pwr, rdy;
  logic [1:0] refsel, done, irq, busy;
  logic [SLOTS-1:0][DATA_W-1:0] res;
  int n_errors = 0;
  int checks_done = 0;
  int n_done [2] = '{0, 0};
  int n_irq [2] = '{0, 0};
  int n_hold = 0;
  ////////////////////////////////////////////////////////////////////////////
  adc_sequencer_control #(.SETTLE_CYCLES(16)) adc_sequencer_control_inst (
    .clk(clk), .rstn(rstn), .clk_en(clk_en), .converter_clock_enable(cce), .halt(halt),
    .fast_peripheral_clock_en(tick), .cfg(cfg), .chan_sel(chan_sel), .trig(trig),
    .analog_input_pin_mv(pin_mv), .analog_low_reference_mv(low_mv),
    .mux_channel_r(mux_ch), .sample_hold_r(hold), .analog_power_up_r(pwr),
    .converter_ready_r(rdy), .reference_select_r(refsel), .results_r(res),
    .sequence_done_r(done), .seq_irq_r(irq), .seq_busy_r(busy)
  );
  analog_front_model analog_front_model_inst (
    .mux_channel_r(mux_ch), .analog_power_up_r(pwr), .levels(lvl), .level_mv(pin_mv)
  );
  initial forever #4 clk = ~clk;
  always @(posedge clk) tick <= slow ? ($urandom_range(0, 3) != 0) : 1'b1;
  always @(posedge clk) begin
    if (hold === 1'b1) n_hold++;
    for (int i = 0; i < 2; i++) begin
      if (done[i] === 1'b1) n_done[i]++;
      if (irq[i] === 1'b1) n_irq[i]++;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [DATA_W-1:0] enc(input logic [MV_W-1:0] v, lo);
    if (v <= lo) return CODE_ZERO;
    if (v >= FULL_RANGE_MV) return CODE_FULL;
    return 12'((32'(v - lo) * 32'h1000) / 32'(FULL_RANGE_MV));
  endfunction : enc
  function automatic logic [CHAN_W-1:0] ch_of(input int s);
    if (cfg.cascade) return chan_sel[s];
    return {s >= HALF_SLOTS, chan_sel[s][2:0]};
  endfunction : ch_of
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (exp !== got) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic pulse(input trigger_type t);
    @(posedge clk) trig <= t;
    @(posedge clk) trig <= '0;
  endtask : pulse
  task automatic wait_done(input int i, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (done[i] !== 1'b1 && n < 3000);
    chk("sequence end seen", 1, 32'(n < 3000));
  endtask : wait_done
  task automatic check_res(input int first, input int cnt);
    for (int s = first; s < first + cnt; s++)
      chk("result", enc(lvl[ch_of(s)], low_mv), res[s]);
  endtask : check_res
  task automatic shuffle(input bit corner);
    logic [SLOTS-1:0][CHAN_W-1:0] cs;
    logic [SLOTS-1:0][MV_W-1:0] lv;
    logic [MV_W-1:0] lo;
    lo = 12'($urandom_range(0, 200));
    for (int k = 0; k < SLOTS; k++) begin
      cs[k] = corner ? 4'(k) : 4'($urandom);
      lv[k] = 12'($urandom_range(0, 4095));
    end
    cs[1] = cs[0];
    if (corner) begin
      lv[0] = lo;
      lv[2] = lo + 12'h001;
      lv[3] = FULL_RANGE_MV;
      lv[4] = FULL_RANGE_MV - 12'h001;
    end
    @(posedge clk);
    chan_sel <= cs;
    lvl <= lv;
    low_mv <= lo;
  endtask : shuffle
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    int n, m, k;
    trigger_type t;
    logic [SLOTS-1:0][DATA_W-1:0] keep;
    void'($urandom(32'h2117));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    pulse(5'h10);
    cyc(3);
    chk("power at reset", 0, pwr);
    chk("busy before enable", 0, busy);
    for (k = 0; k < SLOTS; k++) chk("reset result", 0, res[k]);
    @(posedge clk) cce <= 1'b1;
    cyc(3);
    chk("power on", 1, pwr);
    cyc(9);
    chk("ready early", 0, rdy);
    cyc(11);
    chk("ready", 1, rdy);
    for (k = 0; k < 4; k++) begin
      @(posedge clk) cfg.ref_select <= 2'(k);
      cyc(2);
      chk("reference select", k, refsel);
    end
    $display("test reset_enable done");
    @(posedge clk) cfg.cascade <= 1'b1;
    for (k = 0; k < 2; k++) begin
      @(posedge clk) cfg.acq_prescale <= 4'(3 * k);
      m = n_hold;
      pulse(5'h10);
      wait_done(0, n);
      chk("slot cycles", 13 + 3 * k, n);
      chk("hold cycles", 3 * k + 1, n_hold - m);
    end
    $display("test timing done");
    slow = 1'b1;
    for (m = 0; m < 3; m++) begin
      shuffle(m == 0);
      @(posedge clk);
      cfg.max_conv_casc <= (m == 0) ? 4'hF : 4'($urandom_range(0, 15));
      cfg.acq_prescale <= 4'($urandom_range(0, 3));
      pulse(5'h04);
      wait_done(0, n);
      check_res(0, cfg.max_conv_casc + 1);
      cyc(2);
      chk("busy after end", 0, busy[0]);
    end
    chk("irq each end", n_done[0], n_irq[0]);
    $display("test cascade done");
    @(posedge clk);
    cfg.cascade <= 1'b0;
    cfg.ext_trigger_enable <= 1'b1;
    cfg.every_other_b <= 1'b1;
    for (k = 0; k < 6; k++) begin
      shuffle(1'b0);
      @(posedge clk);
      cfg.max_conv_a <= 3'($urandom);
      cfg.max_conv_b <= 3'($urandom);
      t = (k == 5) ? 5'h06 : 5'(5'h10 >> k);
      pulse(t);
      if (k != 1 && k != 3) begin
        wait_done(0, n);
        check_res(0, cfg.max_conv_a + 1);
        if (k != 5) chk("b untouched", 0, busy[1]);
      end
      if (k == 1 || k == 3 || k == 5) begin
        wait_done(1, n);
        check_res(8, cfg.max_conv_b + 1);
      end
    end
    cyc(2);
    chk("irq b every other", n_done[1] / 2, n_irq[1]);
    $display("test dual done");
    @(posedge clk);
    cfg.cascade <= 1'b1;
    cfg.max_conv_casc <= 4'h0;
    cfg.every_other_a <= 1'b1;
    cyc(2);
    m = n_irq[0];
    for (k = 0; k < 2; k++) begin
      pulse(5'h01);
      wait_done(0, n);
    end
    cyc(2);
    chk("irq per two ends", m + 1, n_irq[0]);
    $display("test every_other done");
    @(posedge clk);
    cfg.every_other_a <= 1'b0;
    cfg.start_stop <= 1'b1;
    cfg.max_conv_casc <= 4'h2;
    shuffle(1'b0);
    m = n_done[0];
    for (k = 0; k < 3; k++) begin
      pulse(5'h10);
      cyc(100);
      chk("stepped result", enc(lvl[ch_of(k)], low_mv), res[k]);
      chk("ends so far", m + (k == 2), n_done[0]);
    end
    $display("test start_stop done");
    @(posedge clk);
    cfg.start_stop <= 1'b0;
    halt <= 1'b1;
    cyc(3);
    chk("power in halt", 0, pwr);
    keep = res;
    m = n_done[0];
    pulse(5'h10);
    cyc(100);
    chk("no end in halt", m, n_done[0]);
    chk("results kept", 1, 32'(keep === res));
    @(posedge clk) halt <= 1'b0;
    wait_done(0, n);
    // A trigger while the global enable is low must be dropped, not pended
    @(posedge clk) clk_en <= 1'b0;
    pulse(5'h10);
    @(posedge clk) clk_en <= 1'b1;
    cyc(2);
    m = n_done[0];
    cyc(200);
    chk("ignored trigger", m, n_done[0]);
    $display("test halt_gate done");
    complete_run();
  end
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    complete_run();
  end
endmodule : adc_sequencer_control_bench
`default_nettype wire

// ### testbench/analog_front_model.sv
// Purpose: Analog multiplexer and input levels facing the converter control.
// Assumes: The bench supplies one level per channel in millivolts.
// Notes: A powered-down front end shows an inverted level, never the real one.
`timescale 1ns/100ps
`default_nettype none
module analog_front_model
  import adc_seq_pkg::*;
(
  input wire logic [CHAN_W-1:0] mux_channel_r,
  input wire logic analog_power_up_r,
  input wire logic [SLOTS-1:0][MV_W-1:0] levels,
  output logic [MV_W-1:0] level_mv
);
  // Unpowered, the pin is not held: a stale value would hide a missing power-up
  assign level_mv = analog_power_up_r ? levels[mux_channel_r] : ~levels[mux_channel_r];
endmodule : analog_front_model
`default_nettype wire
